/* File: include/fdc_cmd_pkg.sv */
// shared constants and types for the track access and drive timing commands
package fdc_cmd_pkg;

    // command byte layout
    localparam logic [7:0] OP_TRACK_MASK = 8'hbf;
    localparam logic [7:0] OP_TRACK = 8'h21;
    localparam logic [7:0] OP_SPECIFY = 8'h03;
    localparam int WRITE_SEL_BIT = 6;
    localparam int HI_SEL_BIT = 2;
    localparam int STEP_HI = 7;
    localparam int STEP_LO = 4;
    localparam int POST_HI = 3;
    localparam int POST_LO = 0;
    localparam int PRE_HI = 7;
    localparam int PRE_LO = 1;
    localparam int DMA_BIT = 0;

    // factor value that a zero field stands for
    localparam logic [7:0] POST_ZERO_AS = 8'h10;
    localparam logic [7:0] PRE_ZERO_AS = 8'h80;
    localparam logic [7:0] STEP_BASE = 8'h10;

    localparam int DRIVES = 4;
    localparam logic [7:0] TRACK_RESET = 8'h00;
    localparam logic [7:0] NO_TRACK_BYTE = 8'h00;

    // timebase: one tick is 1/6 ms, the common divisor of every table entry
    localparam int CLK_HZ = 125000000;
    localparam int TICK_HZ = 6000;
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int DELAY_W = 17;

    // step interval per unit of (16 - code), in ticks
    localparam logic [12:0] STEP_1M = 13'h0003;
    localparam logic [12:0] STEP_500K = 13'h0006;
    localparam logic [12:0] STEP_300K = 13'h000a;
    localparam logic [12:0] STEP_250K = 13'h000c;
    // post-processing constants in ticks: group 0 then group 1
    localparam logic [12:0] POST0_1M = 13'h0030;
    localparam logic [12:0] POST0_500K = 13'h0060;
    localparam logic [12:0] POST0_300K = 13'h00a0;
    localparam logic [12:0] POST0_250K = 13'h00c0;
    localparam logic [12:0] POST1_1M = 13'h0c00;
    localparam logic [12:0] POST1_500K = 13'h0c00;
    localparam logic [12:0] POST1_300K = 13'h1400;
    localparam logic [12:0] POST1_250K = 13'h1800;
    // pre-processing constants in ticks
    localparam logic [12:0] PRE0_1M = 13'h0006;
    localparam logic [12:0] PRE0_500K = 13'h0006;
    localparam logic [12:0] PRE0_300K = 13'h0014;
    localparam logic [12:0] PRE0_250K = 13'h0018;
    localparam logic [12:0] PRE1_1M = 13'h00c0;
    localparam logic [12:0] PRE1_500K = 13'h00c0;
    localparam logic [12:0] PRE1_300K = 13'h0140;
    localparam logic [12:0] PRE1_250K = 13'h0180;

    typedef enum logic [1:0] {
        RATE_500K = 2'h0,
        RATE_300K = 2'h1,
        RATE_250K = 2'h2,
        RATE_1M = 2'h3
    } rate_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ARG1 = 2'h1,
        ST_ARG2 = 2'h3,
        ST_RESULT = 2'h2
    } cmd_state_t;

    typedef struct packed {
        logic [3:0] stepRateCode;
        logic [3:0] postFactor;
        logic [6:0] preFactor;
        logic nonDma;
    } timing_t;

    typedef struct packed {
        rate_t dataRate;
        logic motorTimerGroup;
        logic extendedTrackRange;
        logic fourDrives;
        logic swap02;
    } mode_cfg_t;

endpackage

/* File: design/tick_gen.sv */
// free-running timebase that pulses once per timer unit
`timescale 1ns/1ps
module tick_gen #(
    parameter int CYCLES = fdc_cmd_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    output logic tick
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
        end else if (count_r == LAST) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= (count_r == LAST);
        end
    end
endmodule

/* File: design/delay_timer.sv */
// reloadable down-counter of timebase ticks with a one-cycle done pulse
`timescale 1ns/1ps
module delay_timer #(
    parameter int W = fdc_cmd_pkg::DELAY_W
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic [W-1:0] loadValue,
    input wire logic tick,
    output logic busy,
    output logic done
);
    logic [W-1:0] count_r;

    // restart wins over a running count so each use reloads fresh
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
            busy <= 1'b0;
        end else if (start) begin
            count_r <= loadValue;
            busy <= (loadValue != '0);
        end else if (busy && tick) begin
            count_r <= count_r - 1'b1;
            busy <= (count_r != W'(1));
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= 1'b0;
        end else begin
            done <= (!start && busy && tick && count_r == W'(1)) ||
                    (start && loadValue == '0);
        end
    end
endmodule

/* File: design/fdc_track_and_timing_cmds.sv */
// track-number access and drive timing setup commands with their delay timers
//
// Summary of operation
// - first byte bit 6 chooses reading or overwriting the stored track byte.
// - on a read the third byte is a dummy; stored byte is returned.
// - on a write the third byte replaces the selected track byte.
// - exactly one result byte, equal to the byte read or written, or zero for an absent drive.
// - second byte bit 2 with the drive bits picks drive and track byte.
// - bit 2 low picks the low track byte, high picks the high byte.
// - drive code 00/01 always valid; 10 and 11 depend on drive configuration.
// - timing setup ends without interrupt and without result bytes.
// - timing parameters start undefined and no reset alters them.
// - step code is bits 7-4 of setup byte two, spacing step pulses.
// - step interval is (16 - code) scaled by the data rate.
// - post delay factor is bits 3-0 of byte two; zero means 16.
// - post delay constants depend on data rate and motor timer group.
// - pre delay factor comes from byte three; zero means 128.
// - pre delay constants depend on data rate and motor timer group.
// - motor timer group bit selects the constant set for both delays.
// - byte three bit 0 selects DMA (0) or non-DMA (1) transfers.
`timescale 1ns/1ps
module fdc_track_and_timing_cmds #(
    parameter int TICK_CYCLES = fdc_cmd_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cmdValid,
    input wire logic [7:0] cmdByte,
    output logic cmdReady,
    output logic resValid,
    output logic [7:0] resByte,
    input wire logic resReady,
    input wire fdc_cmd_pkg::mode_cfg_t modeCfg,
    output fdc_cmd_pkg::timing_t timing,
    output logic [fdc_cmd_pkg::DRIVES-1:0][11:0] presentTrack,
    output logic driveSelErr,
    output logic specifyDone,
    input wire logic stepStart,
    output logic stepDue,
    output logic stepBusy,
    input wire logic motorSelStart,
    output logic preDelayDone,
    output logic preDelayBusy,
    input wire logic cmdEndStart,
    output logic postDelayDone,
    output logic postDelayBusy
);
    localparam int DW = fdc_cmd_pkg::DELAY_W;

    fdc_cmd_pkg::cmd_state_t state_r;
    fdc_cmd_pkg::cmd_state_t state_nxt;
    logic opTrack_r;
    logic writeTrack_r;
    logic [7:0] arg1_r;
    logic [7:0] trackMem_r [fdc_cmd_pkg::DRIVES][2];
    fdc_cmd_pkg::timing_t timing_r;
    logic tick;
    logic [DW-1:0] stepLoad;
    logic [DW-1:0] preLoad;
    logic [DW-1:0] postLoad;
    logic takeOp;
    logic takeArg1;
    logic takeArg2;
    logic [1:0] selDrive;
    logic selHigh;
    logic selValid;
    logic trackLast;
    logic setupLast;
    logic [7:0] stepSpan;
    logic [7:0] postFactorEff;
    logic [7:0] preFactorEff;

    function automatic logic isTrackOp(input logic [7:0] b);
        return (b & fdc_cmd_pkg::OP_TRACK_MASK) == fdc_cmd_pkg::OP_TRACK;
    endfunction

    // which drive codes name a drive present in this configuration
    function automatic logic driveValid(input logic [1:0] code,
                                        input fdc_cmd_pkg::mode_cfg_t cfg);
        logic ok;
        ok = 1'b0;
        if (code == 2'h0 || code == 2'h1) begin
            ok = 1'b1;
        end else if (code == 2'h2) begin
            ok = cfg.fourDrives || cfg.swap02;
        end else begin
            ok = cfg.fourDrives;
        end
        return ok;
    endfunction

    // unit constants are ticks of 1/6 ms, so the 300K entries stay whole
    function automatic logic [12:0] stepUnit(input fdc_cmd_pkg::rate_t r);
        logic [12:0] u;
        u = fdc_cmd_pkg::STEP_500K;
        case (r)
            fdc_cmd_pkg::RATE_1M: u = fdc_cmd_pkg::STEP_1M;
            fdc_cmd_pkg::RATE_300K: u = fdc_cmd_pkg::STEP_300K;
            fdc_cmd_pkg::RATE_250K: u = fdc_cmd_pkg::STEP_250K;
            default: u = fdc_cmd_pkg::STEP_500K;
        endcase
        return u;
    endfunction

    function automatic logic [12:0] postUnit(input fdc_cmd_pkg::rate_t r,
                                             input logic grp);
        logic [12:0] u;
        u = fdc_cmd_pkg::POST0_500K;
        case (r)
            fdc_cmd_pkg::RATE_1M: u = grp ? fdc_cmd_pkg::POST1_1M : fdc_cmd_pkg::POST0_1M;
            fdc_cmd_pkg::RATE_300K: u = grp ? fdc_cmd_pkg::POST1_300K : fdc_cmd_pkg::POST0_300K;
            fdc_cmd_pkg::RATE_250K: u = grp ? fdc_cmd_pkg::POST1_250K : fdc_cmd_pkg::POST0_250K;
            default: u = grp ? fdc_cmd_pkg::POST1_500K : fdc_cmd_pkg::POST0_500K;
        endcase
        return u;
    endfunction

    function automatic logic [12:0] preUnit(input fdc_cmd_pkg::rate_t r,
                                            input logic grp);
        logic [12:0] u;
        u = fdc_cmd_pkg::PRE0_500K;
        case (r)
            fdc_cmd_pkg::RATE_1M: u = grp ? fdc_cmd_pkg::PRE1_1M : fdc_cmd_pkg::PRE0_1M;
            fdc_cmd_pkg::RATE_300K: u = grp ? fdc_cmd_pkg::PRE1_300K : fdc_cmd_pkg::PRE0_300K;
            fdc_cmd_pkg::RATE_250K: u = grp ? fdc_cmd_pkg::PRE1_250K : fdc_cmd_pkg::PRE0_250K;
            default: u = grp ? fdc_cmd_pkg::PRE1_500K : fdc_cmd_pkg::PRE0_500K;
        endcase
        return u;
    endfunction

    function automatic logic [DW-1:0] scaleDelay(input logic [12:0] unit,
                                                 input logic [7:0] factor);
        logic [20:0] prod;
        prod = {8'h00, unit} * {13'h0000, factor};
        return prod[DW-1:0];
    endfunction

    // a zero factor field stands for the largest factor
    function automatic logic [7:0] zeroAs(input logic [7:0] f, input logic [7:0] sub);
        return (f == 8'h00) ? sub : f;
    endfunction

    assign takeOp = cmdValid && state_r == fdc_cmd_pkg::ST_IDLE;
    assign takeArg1 = cmdValid && state_r == fdc_cmd_pkg::ST_ARG1;
    assign takeArg2 = cmdValid && state_r == fdc_cmd_pkg::ST_ARG2;
    assign cmdReady = state_r != fdc_cmd_pkg::ST_RESULT;
    assign resValid = state_r == fdc_cmd_pkg::ST_RESULT;
    // the final byte of each command is where it takes effect; setup's step and post fields load at byte two
    assign trackLast = takeArg2 && opTrack_r;
    assign setupLast = takeArg2 && !opTrack_r;

    assign selDrive = arg1_r[1:0];
    assign selHigh = arg1_r[fdc_cmd_pkg::HI_SEL_BIT];
    assign selValid = driveValid(selDrive, modeCfg);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fdc_cmd_pkg::ST_IDLE: begin
                if (takeOp && (isTrackOp(cmdByte) || cmdByte == fdc_cmd_pkg::OP_SPECIFY)) begin
                    state_nxt = fdc_cmd_pkg::ST_ARG1;
                end
            end
            fdc_cmd_pkg::ST_ARG1: begin
                if (takeArg1) begin
                    state_nxt = fdc_cmd_pkg::ST_ARG2;
                end
            end
            fdc_cmd_pkg::ST_ARG2: begin
                if (takeArg2) begin
                    // timing setup has no result phase and raises nothing
                    state_nxt = opTrack_r ? fdc_cmd_pkg::ST_RESULT
                                          : fdc_cmd_pkg::ST_IDLE;
                end
            end
            default: begin
                if (resReady) begin
                    state_nxt = fdc_cmd_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= fdc_cmd_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // opcode capture
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            opTrack_r <= 1'b0;
            writeTrack_r <= 1'b0;
        end else if (takeOp) begin
            opTrack_r <= isTrackOp(cmdByte);
            writeTrack_r <= cmdByte[fdc_cmd_pkg::WRITE_SEL_BIT];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            arg1_r <= 8'h00;
        end else if (takeArg1) begin
            arg1_r <= cmdByte;
        end
    end

    // stored track bytes, low and high per drive
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int d = 0; d < fdc_cmd_pkg::DRIVES; d++) begin
                trackMem_r[d][0] <= fdc_cmd_pkg::TRACK_RESET;
                trackMem_r[d][1] <= fdc_cmd_pkg::TRACK_RESET;
            end
        end else if (trackLast && writeTrack_r && selValid) begin
            trackMem_r[selDrive][selHigh] <= cmdByte;
        end
    end

    // single result byte: the written value, the stored one on a read, or zero for an absent drive
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            resByte <= 8'h00;
        end else if (trackLast) begin
            if (!selValid) begin
                resByte <= fdc_cmd_pkg::NO_TRACK_BYTE;
            end else if (writeTrack_r) begin
                resByte <= cmdByte;
            end else begin
                resByte <= trackMem_r[selDrive][selHigh];
            end
        end
    end

    // absent drive: nothing is stored and a zero byte is returned
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            driveSelErr <= 1'b0;
        end else begin
            driveSelErr <= trackLast && !selValid;
        end
    end

    // no interrupt exists, so this pulse is the only sign that setup ended
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            specifyDone <= 1'b0;
        end else begin
            specifyDone <= setupLast;
        end
    end

    // high nibble only counts with the 12-bit track range on
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            presentTrack <= '0;
        end else begin
            for (int d = 0; d < fdc_cmd_pkg::DRIVES; d++) begin
                presentTrack[d] <= {modeCfg.extendedTrackRange ? trackMem_r[d][1][3:0] : 4'h0,
                                    trackMem_r[d][0]};
            end
        end
    end

    // deliberately outside reset: values survive any reset, undefined at power-up
    always_ff @(posedge core_clk) begin
        if (takeArg1 && !opTrack_r) begin
            timing_r.stepRateCode <= cmdByte[fdc_cmd_pkg::STEP_HI:fdc_cmd_pkg::STEP_LO];
            timing_r.postFactor <= cmdByte[fdc_cmd_pkg::POST_HI:fdc_cmd_pkg::POST_LO];
        end
        if (setupLast) begin
            timing_r.preFactor <= cmdByte[fdc_cmd_pkg::PRE_HI:fdc_cmd_pkg::PRE_LO];
            timing_r.nonDma <= cmdByte[fdc_cmd_pkg::DMA_BIT];
        end
    end

    assign timing = timing_r;

    assign stepSpan = fdc_cmd_pkg::STEP_BASE - {4'h0, timing_r.stepRateCode};
    assign postFactorEff = zeroAs({4'h0, timing_r.postFactor},
                                  fdc_cmd_pkg::POST_ZERO_AS);
    assign preFactorEff = zeroAs({1'b0, timing_r.preFactor},
                                 fdc_cmd_pkg::PRE_ZERO_AS);

    // loads follow the live rate and group, taken at each start
    always_comb begin
        stepLoad = scaleDelay(stepUnit(modeCfg.dataRate), stepSpan);
        postLoad = scaleDelay(postUnit(modeCfg.dataRate, modeCfg.motorTimerGroup),
                              postFactorEff);
        preLoad = scaleDelay(preUnit(modeCfg.dataRate, modeCfg.motorTimerGroup),
                             preFactorEff);
    end

    // one shared free-running timebase: a delay may end up to one tick early
    tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tick(tick)
    );

    delay_timer #(
        .W(DW)
    ) u_step (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .start(stepStart),
        .loadValue(stepLoad),
        .tick(tick),
        .busy(stepBusy),
        .done(stepDue)
    );

    delay_timer #(
        .W(DW)
    ) u_pre (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .start(motorSelStart),
        .loadValue(preLoad),
        .tick(tick),
        .busy(preDelayBusy),
        .done(preDelayDone)
    );

    delay_timer #(
        .W(DW)
    ) u_post (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .start(cmdEndStart),
        .loadValue(postLoad),
        .tick(tick),
        .busy(postDelayBusy),
        .done(postDelayDone)
    );
endmodule

/* File: verif/track_timing_monitor.sv */
// concurrent checks on the command handshake and delay timer ports
`timescale 1ns/1ps
module track_timing_monitor (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire logic resValid,
    input wire logic [7:0] resByte,
    input wire logic resReady,
    input wire logic driveSelErr,
    input wire logic specifyDone,
    input wire logic stepStart,
    input wire logic stepDue,
    input wire logic stepBusy,
    input wire logic motorSelStart,
    input wire logic preDelayBusy,
    input wire logic postDelayDone,
    input wire logic postDelayBusy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_ready_vs_result: assert property (cmdReady != resValid)
        else $error("ready and waiting result overlap");
    a_result_holds: assert property (resValid && !resReady |=> resValid && $stable(resByte))
        else $error("result byte dropped before taken");
    a_single_result: assert property (resValid && resReady |=> !resValid)
        else $error("second result byte offered");
    a_result_after_byte: assert property ($rose(resValid) |-> $past(cmdValid && cmdReady))
        else $error("result without a final command byte");
    a_setup_silent: assert property (specifyDone |=> !specifyDone && !resValid)
        else $error("timing setup produced a result");
    a_absent_drive: assert property (driveSelErr |-> resValid && resByte == 8'h00)
        else $error("absent drive result not zero");
    a_step_busy: assert property (stepStart |=> stepBusy [*2])
        else $error("step timer not counting after start");
    a_step_due_end: assert property (stepDue |-> $past(stepBusy))
        else $error("step pulse without a running interval");
    a_pre_busy: assert property (motorSelStart |=> preDelayBusy)
        else $error("pre delay not counting after start");
    a_post_done_end: assert property (postDelayDone |-> $past(postDelayBusy, 2))
        else $error("post delay ended without running");
endmodule

/* File: verif/host_model.sv */
// host side of the command byte handshake
`timescale 1ns/1ps
module host_model (
    input wire logic core_clk,
    input wire logic cmdReady,
    input wire logic resValid,
    input wire logic [7:0] resByte,
    output logic cmdValid,
    output logic [7:0] cmdByte,
    output logic resReady
);
    initial begin
        cmdValid = 1'b0;
        cmdByte = 8'h00;
        resReady = 1'b0;
    end

    // call at a rising edge; returns at the edge that took the byte
    task automatic send(input logic [7:0] b, inout logic ok);
        logic rdy;
        int n;
        n = 0;
        cmdValid <= 1'b1;
        cmdByte <= b;
        do begin
            @(negedge core_clk);
            rdy = cmdReady;
            n++;
            @(posedge core_clk);
        end while (!rdy && n < 50);
        ok = ok & rdy;
    endtask

    // released byte lines flip so a stale value never passes
    task automatic idle();
        cmdValid <= 1'b0;
        cmdByte <= ~cmdByte;
    endtask

    task automatic take(output logic [7:0] b, inout logic ok);
        logic got;
        int n;
        n = 0;
        resReady <= 1'b1;
        do begin
            @(negedge core_clk);
            got = resValid;
            b = resByte;
            n++;
            @(posedge core_clk);
        end while (!got && n < 50);
        resReady <= 1'b0;
        ok = ok & got;
    endtask

    task automatic setup(input logic [7:0] b1, input logic [7:0] b2, inout logic ok);
        send(8'h03, ok);
        send(b1, ok);
        send(b2, ok);
        idle();
        @(posedge core_clk);
    endtask

    task automatic track(input logic wr, input logic [2:0] sel, input logic [7:0] val,
                         output logic [7:0] res, inout logic ok);
        send({1'b0, wr, 6'h21}, ok);
        send({5'h06, sel}, ok);
        send(val, ok);
        idle();
        take(res, ok);
    endtask
endmodule

/* File: verif/tb.sv */
// command sequences and delay measurements for the track and timing block
`timescale 1ns/1ps
module tb;
    localparam int TC = 4;
    logic core_clk;
    logic arst_n;
    logic cmdValid, cmdReady, resValid, resReady;
    logic [7:0] cmdByte, resByte;
    fdc_cmd_pkg::mode_cfg_t modeCfg;
    fdc_cmd_pkg::timing_t timing;
    logic [fdc_cmd_pkg::DRIVES-1:0][11:0] presentTrack;
    logic driveSelErr, specifyDone;
    logic stepStart, stepDue, stepBusy, motorSelStart, preDelayDone, preDelayBusy;
    logic cmdEndStart, postDelayDone, postDelayBusy;
    int failures = 0;
    int num_checks = 0;

    fdc_track_and_timing_cmds #(.TICK_CYCLES(TC)) i_fdc_track_and_timing_cmds (
        .core_clk(core_clk), .arst_n(arst_n), .cmdValid(cmdValid), .cmdByte(cmdByte),
        .cmdReady(cmdReady), .resValid(resValid), .resByte(resByte), .resReady(resReady),
        .modeCfg(modeCfg), .timing(timing), .presentTrack(presentTrack),
        .driveSelErr(driveSelErr), .specifyDone(specifyDone), .stepStart(stepStart),
        .stepDue(stepDue), .stepBusy(stepBusy), .motorSelStart(motorSelStart),
        .preDelayDone(preDelayDone), .preDelayBusy(preDelayBusy), .cmdEndStart(cmdEndStart),
        .postDelayDone(postDelayDone), .postDelayBusy(postDelayBusy)
    );
    host_model host (
        .core_clk(core_clk), .cmdReady(cmdReady), .resValid(resValid), .resByte(resByte),
        .cmdValid(cmdValid), .cmdByte(cmdByte), .resReady(resReady)
    );

    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // tick phase is free-running, so allow one tick of slack below
    task automatic measure(input int which, input int ticks);
        int n;
        n = 0;
        case (which)
            0: stepStart <= 1'b1;
            1: motorSelStart <= 1'b1;
            default: cmdEndStart <= 1'b1;
        endcase
        @(posedge core_clk);
        {stepStart, motorSelStart, cmdEndStart} <= 3'h0;
        do begin
            @(negedge core_clk);
            n++;
        end while (n < 60000 && (which == 0 ? stepDue : which == 1 ? preDelayDone
                                                                    : postDelayDone) !== 1'b1);
        if (n >= 60000) begin
            failures++;
            $display("[ERR] delay %0d never ended", which);
            finish_test();
        end
        num_checks++;
        if (n < (ticks - 1) * TC || n > ticks * TC + 2) begin
            failures++;
            $display("[ERR] delay %0d expected %0d ticks seen %0d cycles", which, ticks, n);
        end
        @(posedge core_clk);
    endtask

    initial begin
        logic [7:0] r;
        logic ok;
        int unit [4];
        ok = 1'b1;
        unit = '{6, 10, 12, 3};
        arst_n = 1'b0;
        {stepStart, motorSelStart, cmdEndStart} = 3'h0;
        modeCfg = '{fdc_cmd_pkg::RATE_1M, 1'b0, 1'b1, 1'b1, 1'b0};
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        host.setup(8'h00, 8'h00, ok);
        check("timing zero", 16'h0000, timing);
        measure(0, 16 * 3);
        measure(2, 16 * 48);
        measure(1, 128 * 6);
        host.setup(8'hf1, 8'h03, ok);
        check("timing set", 16'hf103, timing);
        for (int i = 0; i < 4; i++) begin
            modeCfg.dataRate <= fdc_cmd_pkg::rate_t'(i);
            @(posedge core_clk);
            measure(0, unit[i]);
        end
        modeCfg.motorTimerGroup <= 1'b1;
        @(posedge core_clk);
        measure(2, 3072);
        measure(1, 192);
        // timing survives a reset in mid-run
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        check("timing after reset", 16'hf103, timing);
        for (int s = 0; s < 8; s++) begin
            host.track(1'b1, 3'(s), 8'ha0 + 8'(s), r, ok);
            check("written byte", 8'ha0 + 8'(s), r);
        end
        for (int s = 0; s < 8; s++) begin
            host.track(1'b0, 3'(s), 8'h5a, r, ok);
            check("read byte", 8'ha0 + 8'(s), r);
        end
        for (int d = 0; d < 4; d++) begin
            check("stored track", {4'h0, 4'(d + 4), 8'ha0 + 8'(d)}, presentTrack[d]);
        end
        host.send(8'h07, ok);
        host.idle();
        @(posedge core_clk);
        host.track(1'b0, 3'h0, 8'h5a, r, ok);
        check("read after stray byte", 8'ha0, r);
        modeCfg.fourDrives <= 1'b0;
        @(posedge core_clk);
        host.track(1'b1, 3'h3, 8'h77, r, ok);
        check("absent drive 3", 8'h00, r);
        host.track(1'b1, 3'h2, 8'h77, r, ok);
        check("absent drive 2", 8'h00, r);
        check("drive 3 kept", 16'h07a3, presentTrack[3]);
        modeCfg.swap02 <= 1'b1;
        @(posedge core_clk);
        host.track(1'b1, 3'h2, 8'h66, r, ok);
        check("swapped drive 2", 8'h66, r);
        modeCfg.extendedTrackRange <= 1'b0;
        repeat (2) @(posedge core_clk);
        check("short track", 16'h00a1, presentTrack[1]);
        check("handshakes", 16'h0001, {15'h0, ok});
        finish_test();
    end
endmodule

bind fdc_track_and_timing_cmds track_timing_monitor i_mon (
    .core_clk(core_clk), .arst_n(arst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .resValid(resValid), .resByte(resByte), .resReady(resReady), .driveSelErr(driveSelErr),
    .specifyDone(specifyDone), .stepStart(stepStart), .stepDue(stepDue), .stepBusy(stepBusy),
    .motorSelStart(motorSelStart), .preDelayBusy(preDelayBusy),
    .postDelayDone(postDelayDone), .postDelayBusy(postDelayBusy)
);
